//--- design/tmc_edge.sv
// Edge detector for one already-synchronous input.
// Assumes the input is synchronous to i_clock.
`timescale 1ns/1ns
`include "tmc_defs.svh"

module tmc_edge
	import tmc_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_level,
	output logic o_rise,
	output logic o_fall
);
	logic last;

	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
			last <= 1'b0;
		else
			last <= i_level;
	end

	assign o_rise = i_level & ~last;
	assign o_fall = ~i_level & last;
endmodule // tmc_edge

//--- design/tmc_pin_comb.sv
// Combines several pins into one capture source by OR or AND.
// Assumes pins synchronous; an unselected pin is simply left out.
`timescale 1ns/1ns
`include "tmc_defs.svh"

module tmc_pin_comb
	import tmc_pkg::*;
(
	input wire logic [`TMC_NCH-1:0] i_pins,
	input wire logic [`TMC_NCH-1:0] i_sel,
	input wire logic i_and,
	output logic o_level
);
	always_comb
	begin
		if (i_and == `TMC_COMB_AND)
			o_level = (i_sel != 4'h0) && ((i_pins & i_sel) == i_sel);
		else
			o_level = |(i_pins & i_sel);
	end
endmodule // tmc_pin_comb

//--- design/tmc_timer.sv
// Timer/counter: 32-bit count, 32-bit prescaler, four match, four capture.
// Assumes control inputs are synchronous; all but i_enable, i_count_reset and i_irq_clear are static configuration.
`timescale 1ns/1ns
`include "tmc_defs.svh"

module tmc_timer
	import tmc_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_enable,
	input wire logic i_count_reset,
	input wire logic [1:0] i_mode,
	input wire logic [1:0] i_count_src,
	input wire logic [`TMC_W-1:0] i_prescale,
	input wire logic [`TMC_W-1:0] i_match0,
	input wire logic [`TMC_W-1:0] i_match1,
	input wire logic [`TMC_W-1:0] i_match2,
	input wire logic [`TMC_W-1:0] i_match3,
	input wire logic [11:0] i_match_ctrl,
	input wire logic [7:0] i_match_act,
	input wire logic [11:0] i_cap_ctrl,
	input wire logic [`TMC_NCH-1:0] i_cap_pins,
	input wire logic [15:0] i_cap_sel,
	input wire logic [`TMC_NCH-1:0] i_cap_and,
	input wire logic [`TMC_NCH-1:0] i_match_out_en,
	input wire logic [`TMC_NCH-1:0] i_irq_clear,
	output logic [`TMC_W-1:0] o_count,
	output logic [`TMC_W-1:0] o_prescale_count,
	output logic [`TMC_W-1:0] o_capture0,
	output logic [`TMC_W-1:0] o_capture1,
	output logic [`TMC_W-1:0] o_capture2,
	output logic [`TMC_W-1:0] o_capture3,
	output logic [`TMC_NCH-1:0] o_match_irq,
	output logic [`TMC_NCH-1:0] o_cap_irq,
	output logic [`TMC_NCH-1:0] o_match_out,
	output logic [15:0] o_match_pins,
	output logic o_halted
);
	// ------------------------------------------------------------
	// Capture input combining and edge detection
	// ------------------------------------------------------------
	logic [`TMC_NCH-1:0] cap_level;
	logic [`TMC_NCH-1:0] cap_rise;
	logic [`TMC_NCH-1:0] cap_fall;
	tmc_word_t match_val [`TMC_NCH];
	tmc_word_t capture [`TMC_NCH];
	tmc_state_e state;
	tmc_word_t count;
	tmc_word_t pcount;

	assign match_val[0] = i_match0;
	assign match_val[1] = i_match1;
	assign match_val[2] = i_match2;
	assign match_val[3] = i_match3;

	genvar g;
	generate
		for (g = 0; g < `TMC_NCH; g++)
		begin : g_cap
			tmc_pin_comb u_comb
			(
				.i_pins(i_cap_pins),
				.i_sel(i_cap_sel[g*4 +: 4]),
				.i_and(i_cap_and[g]),
				.o_level(cap_level[g])
			);
			tmc_edge u_edge
			(
				.i_clock(i_clock),
				.i_rst_n(i_rst_n),
				.i_level(cap_level[g]),
				.o_rise(cap_rise[g]),
				.o_fall(cap_fall[g])
			);
		end
	endgenerate

	// ------------------------------------------------------------
	// Count enable selection
	// ------------------------------------------------------------
	function automatic logic ext_tick(input logic [1:0] mode, input logic r, input logic f);
		case (mode)
			`TMC_MODE_RISE: ext_tick = r;
			`TMC_MODE_FALL: ext_tick = f;
			`TMC_MODE_BOTH: ext_tick = r | f;
			default: ext_tick = 1'b0;
		endcase
	endfunction

	logic tick;
	logic step;
	logic running;
	logic [`TMC_NCH-1:0] match_hit;
	logic any_reset;
	logic any_stop;

	assign running = (state == TMC_RUN);
	// Pulses shorter than a clock are missed; source must hold a full period
	always_comb
	begin
		if (i_mode == `TMC_MODE_TIMER)
			tick = running;
		else
			tick = running && ext_tick(i_mode, cap_rise[i_count_src],
				cap_fall[i_count_src]);
	end

	assign step = tick && (pcount == i_prescale);

	// Match only counts when this step is about to move the count onto the value
	always_comb
	begin
		for (int i = 0; i < `TMC_NCH; i++)
			match_hit[i] = step && ((count + `TMC_ONE) == match_val[i]);
	end

	always_comb
	begin
		any_reset = 1'b0;
		any_stop = 1'b0;
		for (int i = 0; i < `TMC_NCH; i++)
		begin
			any_reset = any_reset | (match_hit[i] & i_match_ctrl[i*3 + `TMC_MC_RESET]);
			any_stop = any_stop | (match_hit[i] & i_match_ctrl[i*3 + `TMC_MC_STOP]);
		end
	end

	// ------------------------------------------------------------
	// Run state
	// ------------------------------------------------------------
	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
			state <= TMC_IDLE;
		else
		begin
			case (state)
				TMC_IDLE: if (i_enable) state <= TMC_RUN;
				TMC_RUN:
				begin
					if (any_stop)
						state <= TMC_HALT;
					else if (!i_enable)
						state <= TMC_IDLE;
				end
				TMC_HALT: if (!i_enable) state <= TMC_IDLE;
				default: state <= TMC_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
			o_halted <= 1'b0;
		else
			o_halted <= (state == TMC_HALT) || (running && any_stop);
	end

	// ------------------------------------------------------------
	// Prescaler and count
	// ------------------------------------------------------------
	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
			pcount <= `TMC_ZERO;
		else if (i_count_reset || step)
			pcount <= `TMC_ZERO;
		else if (tick)
			pcount <= pcount + `TMC_ONE;
	end

	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
			count <= `TMC_ZERO;
		else if (i_count_reset || any_reset)
			count <= `TMC_ZERO;
		else if (step)
			count <= count + `TMC_ONE;
	end

	assign o_count = count;
	assign o_prescale_count = pcount;

	// ------------------------------------------------------------
	// Capture registers and interrupt flags
	// ------------------------------------------------------------
	function automatic logic cap_take(input logic r, input logic f, input logic [2:0] ctrl);
		cap_take = (r & ctrl[`TMC_CC_RISE]) | (f & ctrl[`TMC_CC_FALL]);
	endfunction

	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			for (int i = 0; i < `TMC_NCH; i++)
				capture[i] <= `TMC_ZERO;
		end
		else
		begin
			for (int i = 0; i < `TMC_NCH; i++)
				if (cap_take(cap_rise[i], cap_fall[i], i_cap_ctrl[i*3 +: 3]))
					capture[i] <= count;
		end
	end

	assign o_capture0 = capture[0];
	assign o_capture1 = capture[1];
	assign o_capture2 = capture[2];
	assign o_capture3 = capture[3];

	// Set wins over a same-cycle clear so no event is lost
	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_match_irq <= 4'h0;
			o_cap_irq <= 4'h0;
		end
		else
		begin
			for (int i = 0; i < `TMC_NCH; i++)
			begin
				if (match_hit[i] & i_match_ctrl[i*3 + `TMC_MC_IRQ])
					o_match_irq[i] <= 1'b1;
				else if (i_irq_clear[i])
					o_match_irq[i] <= 1'b0;
				if (cap_take(cap_rise[i], cap_fall[i], i_cap_ctrl[i*3 +: 3]) &
					i_cap_ctrl[i*3 + `TMC_CC_IRQ])
					o_cap_irq[i] <= 1'b1;
				else if (i_irq_clear[i])
					o_cap_irq[i] <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// External match outputs
	// ------------------------------------------------------------
	function automatic logic apply_act(input logic [1:0] act, input logic cur);
		case (act)
			`TMC_ACT_LOW: apply_act = 1'b0;
			`TMC_ACT_HIGH: apply_act = 1'b1;
			`TMC_ACT_TOGGLE: apply_act = ~cur;
			default: apply_act = cur;
		endcase
	endfunction

	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
			o_match_out <= 4'h0;
		else
			for (int i = 0; i < `TMC_NCH; i++)
				if (match_hit[i])
					o_match_out[i] <= apply_act(i_match_act[i*2 +: 2], o_match_out[i]);
	end

	// Broadcast: each match output fans to four pins, pin p of every group gated by enable bit p
	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
			o_match_pins <= 16'h0000;
		else
			for (int i = 0; i < `TMC_NCH; i++)
				for (int p = 0; p < `TMC_NCH; p++)
					o_match_pins[i*4 + p] <= i_match_out_en[p] &
						(match_hit[i] ? apply_act(i_match_act[i*2 +: 2], o_match_out[i])
						: o_match_out[i]);
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	a_reset_to_zero: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		(any_reset && !i_count_reset) |=> count == `TMC_ZERO)
		else $error("count not zero after reset match");
	a_stop_halts: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		(running && any_stop && i_enable) |=> state == TMC_HALT ##1 $stable(count))
		else $error("counter did not halt on stop match");
	a_step_advance: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		(step && !any_reset && !i_count_reset) |=> count == $past(count) + `TMC_ONE)
		else $error("count missed a step");
	a_prescale_wrap: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		(step && !i_count_reset) |=> pcount == `TMC_ZERO)
		else $error("prescaler did not wrap");
	a_prescale_hold: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		(!tick && !i_count_reset) |=> $stable(pcount))
		else $error("prescaler moved without tick");
	a_capture_latch: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		(cap_rise[0] && i_cap_ctrl[`TMC_CC_RISE]) |=> capture[0] == $past(count))
		else $error("capture 0 missed count");
	a_cap_flag_set: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		(cap_rise[1] && i_cap_ctrl[3 + `TMC_CC_RISE] && i_cap_ctrl[3 + `TMC_CC_IRQ])
		|=> o_cap_irq[1])
		else $error("capture flag not set");
	a_match_flag_set: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		(match_hit[0] && i_match_ctrl[`TMC_MC_IRQ]) |=> o_match_irq[0])
		else $error("match flag not set");
	a_toggle_out: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		(match_hit[0] && i_match_act[1:0] == `TMC_ACT_TOGGLE)
		|=> o_match_out[0] != $past(o_match_out[0]))
		else $error("match output did not toggle");
	a_match_equal: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		(match_hit[1] && !any_reset && !i_count_reset) |=> count == i_match1)
		else $error("match with unequal count");
endmodule // tmc_timer

//--- include/tmc_defs.svh
// Constants for the timer/counter with capture and match.
// Assumes inclusion by bare name from design files and the package.
`ifndef TMC_DEFS_SVH
`define TMC_DEFS_SVH

`define TMC_W 32
`define TMC_NCH 4
`define TMC_ZERO 32'h00000000
`define TMC_ONE 32'h00000001
// Counting mode field
`define TMC_MODE_TIMER 2'h0
`define TMC_MODE_RISE 2'h1
`define TMC_MODE_FALL 2'h2
`define TMC_MODE_BOTH 2'h3
// External match action field
`define TMC_ACT_NONE 2'h0
`define TMC_ACT_LOW 2'h1
`define TMC_ACT_HIGH 2'h2
`define TMC_ACT_TOGGLE 2'h3
// Per-channel match control bit positions
`define TMC_MC_IRQ 0
`define TMC_MC_RESET 1
`define TMC_MC_STOP 2
// Per-channel capture control bit positions
`define TMC_CC_RISE 0
`define TMC_CC_FALL 1
`define TMC_CC_IRQ 2
// Pin combiner select
`define TMC_COMB_OR 1'h0
`define TMC_COMB_AND 1'h1

`endif

//--- include/tmc_pkg.sv
// Types shared by the timer/counter design files.
// Assumes tmc_defs.svh is on the include path.
`include "tmc_defs.svh"

package tmc_pkg;
	typedef logic [`TMC_W-1:0] tmc_word_t;
	typedef enum logic [2:0]
	{
		TMC_IDLE = 3'h1,
		TMC_RUN = 3'h2,
		TMC_HALT = 3'h4
	} tmc_state_e;
endpackage

//--- tb/tb_top.sv
// Bench for the timer: match, capture and event counting runs.
// Assumes tmc_ev_src drives the capture pins.
`timescale 1ns/1ns
`include "tmc_defs.svh"

module tb_top
	import tmc_pkg::*;
	;
	logic i_clock = 1'b0;
	logic i_rst_n = 1'b0;
	logic en = 1'b0;
	logic crst = 1'b0;
	logic halted;
	logic hprev = 1'b0;
	logic [1:0] md = `TMC_MODE_TIMER;
	logic [1:0] src = 2'h0;
	logic [3:0] fire = 4'h0;
	logic [3:0] len = 4'h1;
	logic [3:0] clr = 4'h0;
	logic [3:0] cprev = 4'h0;
	logic [3:0] oen = 4'h5;
	logic [3:0] pins, mirq, cirq, mout, eo;
	logic [7:0] act = 8'h00;
	logic [11:0] mctl = 12'h000;
	logic [11:0] cctl = 12'h000;
	logic [15:0] mpins, ep;
	logic [31:0] psc = 32'h0;
	logic [31:0] seed = 32'h0000C998;
	logic [31:0] m, mx, cnt, pcnt;
	logic [31:0] mv [4] = '{default: 32'hFFFFFFFF};
	logic [31:0] cap [4];
	logic [39:0] hx;
	logic [33:0] cx;
	logic [39:0] q_halt [$];
	logic [33:0] q_cap [$];
	int err_total = 0;
	int check_count = 0;
	int np;

	always #20 i_clock = ~i_clock;

	tmc_timer i_dut
	(
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.i_enable(en),
		.i_count_reset(crst),
		.i_mode(md),
		.i_count_src(src),
		.i_prescale(psc),
		.i_match0(mv[0]),
		.i_match1(mv[1]),
		.i_match2(mv[2]),
		.i_match3(mv[3]),
		.i_match_ctrl(mctl),
		.i_match_act(act),
		.i_cap_ctrl(cctl),
		.i_cap_pins(pins),
		.i_cap_sel(16'hCC21),
		.i_cap_and(4'h4),
		.i_match_out_en(oen),
		.i_irq_clear(clr),
		.o_count(cnt),
		.o_prescale_count(pcnt),
		.o_capture0(cap[0]),
		.o_capture1(cap[1]),
		.o_capture2(cap[2]),
		.o_capture3(cap[3]),
		.o_match_irq(mirq),
		.o_cap_irq(cirq),
		.o_match_out(mout),
		.o_match_pins(mpins),
		.o_halted(halted)
	);

	tmc_ev_src i_src
	(
		.i_clock(i_clock),
		.i_fire(fire),
		.i_len(len),
		.o_pins(pins)
	);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic check_val(input string what, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e)
		begin
			err_total++;
			$display("CHECK FAILED %s exp %h got %h", what, e, g);
		end
	endtask

	task automatic stop_test();
		if (err_total == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(negedge i_clock);
	endtask

	// Drop enable so a halted counter can start again
	task automatic restart();
		en = 1'b0;
		crst = 1'b1;
		clr = 4'hF;
		tick(1);
		crst = 1'b0;
		clr = 4'h0;
		tick(1);
	endtask

	task automatic pulse(input logic [3:0] msk);
		len = 4'(rnd() % 4 + 1);
		fire = msk;
		tick(1);
		fire = 4'h0;
		tick(8);
	endtask

	task automatic run_halt(input logic [39:0] note);
		int n;
		n = 0;
		q_halt.push_back(note);
		en = 1'b1;
		while (halted !== 1'b1 && n < 500)
		begin
			@(posedge i_clock);
			#1;
			n++;
			if (n == 2)
				check_val("prescale run", (psc == 32'h0) ? 32'h0 : 32'h1, pcnt);
		end
		check_val("halt cycles", 1 + note[39:8] * (psc + 1), 32'(n));
		tick(1);
	endtask

	// ----------------------------------------
	// Result monitor
	// ----------------------------------------
	always @(posedge i_clock)
	begin
		#1;
		if (halted && !hprev && q_halt.size() > 0)
		begin
			hx = q_halt.pop_front();
			check_val("halt count", hx[39:8], cnt);
			check_val("match out", {28'h0, hx[7:4]}, {28'h0, mout});
			check_val("match irq", {28'h0, hx[3:0]}, {28'h0, mirq});
		end
		for (int k = 0; k < 4; k++)
		begin
			if (cirq[k] && !cprev[k] && q_cap.size() > 0)
			begin
				cx = q_cap.pop_front();
				check_val("cap chan", {30'h0, cx[33:32]}, k[31:0]);
				check_val("cap value", cx[31:0], cap[k]);
			end
		end
		hprev = halted;
		cprev = cirq;
	end

	initial
	begin
		#(40 * 20000);
		err_total++;
		stop_test();
	end

	initial
	begin
		tick(6);
		i_rst_n = 1'b1;
		check_val("reset count", 32'h0, cnt);
		check_val("reset outs", 32'h0, {mpins, mout, mirq, cirq, 3'h0, halted});
		tick(1);
		// Two runs walk all four output actions
		for (int r = 0; r < 2; r++)
		begin
			psc = rnd() % 4;
			m = 6 + rnd() % 4;
			mv = '{m, 32'h1, 32'h3, 32'h2};
			mctl = 12'h20D;
			act = r ? 8'h9F : 8'h2B;
			cctl = 12'hD4D;
			eo = r ? 4'h8 : 4'h7;
			run_halt({m, eo, 4'hB});
			for (int i = 0; i < 4; i++)
				ep[i*4 +: 4] = eo[i] ? oen : 4'h0;
			check_val("match pins", {16'h0, ep}, {16'h0, mpins});
			q_cap.push_back({2'h0, m});
			pulse(4'h1);
			pulse(4'h2);
			check_val("cap no irq", m, cap[1]);
			check_val("cap irq off", 32'h0, {31'h0, cirq[1]});
			q_cap.push_back({2'h3, m});
			pulse(4'h4);
			check_val("and one pin", 32'h0, {31'h0, cirq[2]});
			q_cap.push_back({2'h2, m});
			pulse(4'hC);
			check_val("held count", m, cnt);
			restart();
		end
		psc = 32'h0;
		mv[0] = 32'h4;
		mctl = 12'h003;
		act = 8'h03;
		en = 1'b1;
		mx = 32'h0;
		for (int i = 0; i < 40; i++)
		begin
			tick(1);
			if (cnt > mx)
				mx = cnt;
		end
		check_val("wrap max", 32'h3, mx);
		check_val("wrap irq", 32'h1, {31'h0, mirq[0]});
		check_val("wrap run", 32'h0, {31'h0, halted});
		restart();
		mctl = 12'h000;
		act = 8'h00;
		cctl = 12'h028;
		for (int k = 1; k < 4; k++)
		begin
			md = 2'(k);
			src = (k == 3) ? 2'h3 : 2'h0;
			en = 1'b1;
			tick(2);
			np = 2 + rnd() % 3;
			repeat (np)
				pulse((k == 3) ? 4'h4 : 4'h1);
			m = (k == 3) ? 2 * np : np;
			check_val("event count", m, cnt);
			q_cap.push_back({2'h1, m});
			pulse(4'h2);
			restart();
		end
		check_val("notes left", 32'h0, q_halt.size() + q_cap.size());
		stop_test();
	end
endmodule // tb_top

//--- tb/tmc_ev_src.sv
// Event source model: drives the capture pins as timed pulses.
// Assumes fire requests last one cycle and change at the falling edge.
`timescale 1ns/1ns

module tmc_ev_src
(
	input wire logic i_clock,
	input wire logic [3:0] i_fire,
	input wire logic [3:0] i_len,
	output logic [3:0] o_pins
);
	logic [3:0] left [4] = '{default: 4'h0};

	// Pulse lasts i_len whole cycles; an i_len of zero gives no pulse
	always_ff @(posedge i_clock)
	begin
		for (int k = 0; k < 4; k++)
		begin
			if (i_fire[k])
				left[k] <= i_len;
			else if (left[k] != 4'h0)
				left[k] <= left[k] - 4'h1;
		end
	end

	always_comb
	begin
		for (int k = 0; k < 4; k++)
			o_pins[k] = (left[k] != 4'h0);
	end
endmodule // tmc_ev_src
